// ### logic/wdr_pkg.sv
package wdr_pkg;

    // System clock and the internal low-speed oscillator it stands in for.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned LS_OSC_FREQ_HZ = 264_000;
    // One low-speed period in system cycles, rounded down so the watchdog never runs slow.
    localparam int unsigned LS_TICK_CYCLES = CLK_HZ / LS_OSC_FREQ_HZ;

    // Register map.
    localparam logic [15:0] CLEAR_KEY_ADDR = 16'hff99;
    localparam logic [15:0] RESET_CAUSE_ADDR = 16'hff41;

    // Clear-key values.
    localparam logic [7:0] KEY_VALID = 8'hac;
    localparam logic [7:0] KEY_READ_ENABLED = 8'h9a;
    localparam logic [7:0] KEY_READ_DISABLED = 8'h1a;

    // Option-byte field positions.
    localparam int unsigned OPT_WIN_LSB = 5;
    localparam int unsigned OPT_EN_BIT = 4;
    localparam int unsigned OPT_OVF_LSB = 1;
    localparam logic [7:0] OPT_RESET = 8'h00;

    // Counter geometry: periods run from 2^10 to 2^17 low-speed cycles.
    localparam int unsigned CNT_W = 17;
    localparam logic [2:0] OVF_SEL_MAX = 3'h7;

    // Position of the watchdog cause flag in the reset-cause register.
    localparam int unsigned CAUSE_DOG_BIT = 4;

    // Memory map used by the illegal-access check.
    localparam logic [15:0] EXEMPT_BASE = 16'hfb00;
    localparam int unsigned CODE_UNIT_SHIFT = 12;
    localparam int unsigned RAM_UNIT_SHIFT = 8;

    // Length of the internal reset request in system cycles.
    localparam int unsigned RESET_HOLD_CYCLES = 16;

    typedef enum logic [1:0] {
        WDR_LOAD,
        WDR_RUN,
        WDR_HOLD
    } wdr_state_t;

endpackage

// ### logic/wdr_tick_div.sv
`timescale 1ns/1ns
module wdr_tick_div #(
    parameter int unsigned DIV = 378
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Oscillator running; a stopped oscillator freezes the divider.
    input wire logic run_in,
    // One-cycle pulse per low-speed period.
    output logic tick_out
);
    logic [$clog2(DIV+1)-1:0] cnt_r;
    localparam logic [$clog2(DIV+1)-1:0] LAST = ($clog2(DIV+1))'(DIV - 1);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else if (run_in) begin
            if (cnt_r == LAST) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign tick_out = run_in && (cnt_r == LAST);
endmodule

// ### logic/wdr_addr_check.sv
`timescale 1ns/1ns
module wdr_addr_check
    import wdr_pkg::*;
(
    // Memory size settings.
    input wire logic [7:0] imem_size_in,
    input wire logic [7:0] xmem_size_in,
    // Core accesses.
    input wire logic fetch_valid_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic data_valid_in,
    input wire logic [15:0] data_addr_in,
    // Fault flags, combinational.
    output logic fetch_fault_out,
    output logic data_fault_out
);
    logic [16:0] code_limit;
    logic [15:0] ram_base;

    // Code space grows from zero in 4 KB units from both size settings; internal
    // RAM grows down from the exempt top range in 256-byte units.
    always_comb begin
        code_limit = 17'({5'h0, imem_size_in[3:0]} + {5'h0, xmem_size_in[3:0]})
            << CODE_UNIT_SHIFT;
        ram_base = EXEMPT_BASE - (16'({4'h0, imem_size_in[7:4]}) << RAM_UNIT_SHIFT);
    end

    assign fetch_fault_out = fetch_valid_in && ({1'b0, fetch_addr_in} >= code_limit);
    assign data_fault_out = data_valid_in && ({1'b0, data_addr_in} >= code_limit)
        && (data_addr_in < ram_base) && (data_addr_in < EXEMPT_BASE);
endmodule

// ### logic/wdr_top.sv
`timescale 1ns/1ns
// How it works
// - The watchdog counter advances only on low-speed oscillator ticks.
// - Overflow before a valid clear raises the internal reset.
// - A single-bit access to the clear-key register raises the internal reset.
// - Writing any byte but the valid key raises the internal reset.
// - A key write during the closed window raises the internal reset.
// - An instruction fetch outside enabled memory raises the internal reset.
// - A data access outside enabled memory, top range exempt, raises reset.
// - A watchdog reset sets bit 4 of the reset-cause register.
// - Option byte gives window select, enable and overflow select fields.
// - The valid key clears the counter to zero and counting restarts.
// - Clear-key reset value follows the enable option bit.
// - Reading the clear-key register returns that reset value, never the key.
// - Key faults while the oscillator stops wait and fire on resumption.
// - Overflow select picks 2^10 to 2^17 low-speed cycles, ascending.
// - Window select gives 25, 50, 75 or 100 percent open, ascending.
// - The first key write after release clears regardless of window.
// - Enable option starts counting and access checks; otherwise both stay off.
module wdr_top
    import wdr_pkg::*;
#(
    parameter int unsigned LS_DIV = LS_TICK_CYCLES,
    parameter int unsigned HOLD = RESET_HOLD_CYCLES
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Option byte and oscillator status.
    input wire logic [7:0] opt_byte_in,
    input wire logic ls_osc_run_in,
    // Register port.
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wr_data_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_bit_op_in,
    output logic [7:0] reg_rd_data_out,
    // Memory size settings and core accesses.
    input wire logic [7:0] imem_size_in,
    input wire logic [7:0] xmem_size_in,
    input wire logic fetch_valid_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic data_valid_in,
    input wire logic [15:0] data_addr_in,
    // Status and reset request.
    output logic wdt_reset_req_out,
    output logic dog_reset_cause_flag_out,
    output logic window_open_out
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    wdr_state_t state_r;
    logic [7:0] opt_r;
    logic [CNT_W-1:0] cnt_r;
    logic first_write_r;
    logic pend_r;
    logic [$clog2(HOLD+1)-1:0] hold_r;
    logic cause_r;
    logic [7:0] rd_data_r;

    logic ls_tick;
    logic fetch_fault;
    logic data_fault;

    logic counter_enable_option;
    logic [1:0] open_period_select;
    logic [2:0] overflow_time_select;
    logic [CNT_W-1:0] cnt_last;
    logic [CNT_W-1:0] quarter;
    logic [CNT_W-1:0] closed_end;
    logic window_open;
    logic key_hit_wr;
    logic bit_op_hit;
    logic bad_key;
    logic closed_write;
    logic good_clear;
    logic key_fault;
    logic overflow;
    logic access_fault;
    logic fire;
    logic running;

    localparam logic [$clog2(HOLD+1)-1:0] HOLD_LAST = ($clog2(HOLD+1))'(HOLD - 1);

    // Reset release passes through two flops; the async assert stays immediate.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    // The counter is advanced only by this tick, never by the core clocking.
    wdr_tick_div #(
        .DIV(LS_DIV)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .run_in(ls_osc_run_in),
        .tick_out(ls_tick)
    );

    wdr_addr_check u_check (
        .imem_size_in(imem_size_in),
        .xmem_size_in(xmem_size_in),
        .fetch_valid_in(fetch_valid_in),
        .fetch_addr_in(fetch_addr_in),
        .data_valid_in(data_valid_in),
        .data_addr_in(data_addr_in),
        .fetch_fault_out(fetch_fault),
        .data_fault_out(data_fault)
    );

    // Option fields come from the byte latched at release.
    assign counter_enable_option = opt_r[OPT_EN_BIT];
    assign open_period_select = opt_r[OPT_WIN_LSB +: 2];
    assign overflow_time_select = opt_r[OPT_OVF_LSB +: 3];
    assign running = (state_r == WDR_RUN);

    always_comb begin
        // Last count before overflow is 2^(10+sel)-1.
        cnt_last = {CNT_W{1'b1}} >> (OVF_SEL_MAX - overflow_time_select);
        quarter = (cnt_last >> 2) + 1'b1;
        // Closed part covers the leading quarters; the open tail is the chosen share.
        case (open_period_select)
            2'h0: closed_end = CNT_W'({quarter, 1'b0} + {1'b0, quarter});
            2'h1: closed_end = CNT_W'({quarter, 1'b0});
            2'h2: closed_end = quarter;
            default: closed_end = '0;
        endcase
    end

    // The first clear after release skips the window check.
    assign window_open = first_write_r || (cnt_r >= closed_end);

    assign key_hit_wr = running && reg_wr_in && (reg_addr_in == CLEAR_KEY_ADDR);
    // Set, clear or test of one bit shows up as a strobe with the bit flag high.
    assign bit_op_hit = running && (reg_wr_in || reg_rd_in) && reg_bit_op_in
        && (reg_addr_in == CLEAR_KEY_ADDR);
    assign bad_key = key_hit_wr && (reg_wr_data_in != KEY_VALID);
    assign closed_write = key_hit_wr && counter_enable_option && !window_open
        && (reg_wr_data_in == KEY_VALID);
    assign good_clear = key_hit_wr && !reg_bit_op_in && (reg_wr_data_in == KEY_VALID)
        && !closed_write;
    assign key_fault = bit_op_hit || bad_key || closed_write;

    assign overflow = running && counter_enable_option && ls_tick
        && (cnt_r == cnt_last) && !good_clear;
    assign access_fault = running && counter_enable_option
        && (fetch_fault || data_fault);

    // Key faults wait for a running oscillator; everything else fires at once.
    assign fire = overflow || access_fault
        || ((key_fault || pend_r) && ls_osc_run_in);

    // Sequencing: latch options, run, then hold the reset request for a while.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= WDR_LOAD;
        end else begin
            case (state_r)
                WDR_LOAD: state_r <= WDR_RUN;
                WDR_RUN: begin
                    if (fire) begin
                        state_r <= WDR_HOLD;
                    end
                end
                WDR_HOLD: begin
                    if (hold_r == HOLD_LAST) begin
                        state_r <= WDR_RUN;
                    end
                end
                default: state_r <= WDR_LOAD;
            endcase
        end
    end

    // The option byte is a strap, so it is caught by the clock after release.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            opt_r <= OPT_RESET;
        end else if (state_r == WDR_LOAD) begin
            opt_r <= opt_byte_in;
        end
    end

    // Counter: off unless enabled, zeroed by a clear or by the watchdog reset.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!running || good_clear) begin
            cnt_r <= '0;
        end else if (counter_enable_option && ls_tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            first_write_r <= 1'b1;
        end else if (!running) begin
            first_write_r <= 1'b1;
        end else if (key_hit_wr) begin
            first_write_r <= 1'b0;
        end
    end

    // Pending fault from a stopped oscillator.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
        end else if (!running) begin
            pend_r <= 1'b0;
        end else if (key_fault && !ls_osc_run_in) begin
            pend_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= '0;
        end else if (state_r == WDR_HOLD) begin
            hold_r <= hold_r + 1'b1;
        end else begin
            hold_r <= '0;
        end
    end

    // The cause flag survives the watchdog reset itself; only the external reset
    // or a read of the cause register clears it, and a new cause wins the tie.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= 1'b0;
        end else if (running && fire) begin
            cause_r <= 1'b1;
        end else if (reg_rd_in && (reg_addr_in == RESET_CAUSE_ADDR)) begin
            cause_r <= 1'b0;
        end
    end

    // Read data stands for exactly one cycle after the strobe.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h00;
        end else if (reg_rd_in && (reg_addr_in == CLEAR_KEY_ADDR)) begin
            rd_data_r <= counter_enable_option ? KEY_READ_ENABLED
                : KEY_READ_DISABLED;
        end else if (reg_rd_in && (reg_addr_in == RESET_CAUSE_ADDR)) begin
            rd_data_r <= 8'(cause_r) << CAUSE_DOG_BIT;
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    assign reg_rd_data_out = rd_data_r;
    assign wdt_reset_req_out = (state_r == WDR_HOLD);
    assign dog_reset_cause_flag_out = cause_r;
    assign window_open_out = running && counter_enable_option && window_open;
endmodule

// ### bench/wdr_core_model.sv
`timescale 1ns/1ns
module wdr_core_model (
    // Clock and read data.
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    // Register bus.
    output logic [15:0] addr_out = 16'h0000,
    output logic [7:0] wdata_out = 8'h00,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0,
    output logic bit_out = 1'b0,
    // Fetch and data accesses.
    output logic fv_out = 1'b0,
    output logic [15:0] fa_out = 16'h0000,
    output logic dv_out = 1'b0,
    output logic [15:0] da_out = 16'h0000
);
    // Released lines show the inverse so a stale value never looks valid.
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        bit_out <= b;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        bit_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1 d = rdata_in;
    endtask
    task automatic acc(input logic f, input logic [15:0] a);
        @(posedge clk_in);
        fv_out <= f;
        dv_out <= !f;
        fa_out <= a;
        da_out <= a;
        @(posedge clk_in);
        fv_out <= 1'b0;
        dv_out <= 1'b0;
        fa_out <= ~a;
        da_out <= ~a;
    endtask
endmodule

// ### bench/wdr_monitor.sv
`timescale 1ns/1ns
module wdr_monitor
    import wdr_pkg::*;
#(
    parameter int unsigned HOLD = RESET_HOLD_CYCLES
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Watched ports.
    input wire logic [7:0] opt_byte_in,
    input wire logic ls_osc_run_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wr_data_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_bit_op_in,
    input wire logic [7:0] reg_rd_data_out,
    input wire logic [7:0] imem_size_in,
    input wire logic [7:0] xmem_size_in,
    input wire logic fetch_valid_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic data_valid_in,
    input wire logic [15:0] data_addr_in,
    input wire logic wdt_reset_req_out,
    input wire logic dog_reset_cause_flag_out,
    input wire logic window_open_out
);
    logic [2:0] live_r;
    logic [7:0] hold_r;
    logic [16:0] code_lim;
    logic key_wr;
    logic en;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Requests before the option byte is latched are ignored, so they are not judged.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            live_r <= 3'h0;
            hold_r <= 8'h00;
        end else begin
            live_r <= live_r[2] ? live_r : live_r + 3'h1;
            hold_r <= wdt_reset_req_out ? hold_r + 8'h01 : 8'h00;
        end
    end
    assign en = opt_byte_in[OPT_EN_BIT];
    assign code_lim = ({1'b0, imem_size_in[3:0]} + {1'b0, xmem_size_in[3:0]}) << 12;
    assign key_wr = reg_wr_in && reg_addr_in == CLEAR_KEY_ADDR && live_r[2]
        && !wdt_reset_req_out && ls_osc_run_in;
    sequence s_raised;
        !wdt_reset_req_out ##1 wdt_reset_req_out;
    endsequence
    chk_bad_key: assert property (key_wr && !reg_bit_op_in && reg_wr_data_in != KEY_VALID
        |=> wdt_reset_req_out) else $error("bad key gave no reset");
    chk_bit_op: assert property (key_wr && reg_bit_op_in |=> wdt_reset_req_out)
        else $error("bit access gave no reset");
    chk_closed_window: assert property (key_wr && !reg_bit_op_in && en && !window_open_out
        && reg_wr_data_in == KEY_VALID |=> wdt_reset_req_out) else $error("closed write missed");
    chk_fetch_guard: assert property (fetch_valid_in && en && live_r[2]
        && !wdt_reset_req_out && {1'b0, fetch_addr_in} >= code_lim |=> wdt_reset_req_out)
        else $error("fetch missed");
    chk_hold_length: assert property (!wdt_reset_req_out && $past(wdt_reset_req_out)
        |-> hold_r == 8'(HOLD)) else $error("reset request length wrong");
    chk_cause_flag: assert property (s_raised |-> dog_reset_cause_flag_out)
        else $error("cause flag not set");
    chk_key_readback: assert property (reg_rd_in && !reg_bit_op_in && live_r[2]
        && reg_addr_in == CLEAR_KEY_ADDR |=> reg_rd_data_out == (en ? KEY_READ_ENABLED
        : KEY_READ_DISABLED)) else $error("key readback wrong");
    chk_disabled_quiet: assert property (!en && live_r[2] && !reg_wr_in && !reg_rd_in
        && !$past(reg_wr_in) && !$past(reg_rd_in) && ls_osc_run_in && $past(ls_osc_run_in)
        && !wdt_reset_req_out |=> !wdt_reset_req_out) else $error("disabled dog reset");
endmodule
bind wdr_top wdr_monitor #(.HOLD(HOLD)) u_mon (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .opt_byte_in(opt_byte_in), .ls_osc_run_in(ls_osc_run_in), .reg_addr_in(reg_addr_in),
    .reg_wr_data_in(reg_wr_data_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_bit_op_in(reg_bit_op_in), .reg_rd_data_out(reg_rd_data_out),
    .imem_size_in(imem_size_in), .xmem_size_in(xmem_size_in),
    .fetch_valid_in(fetch_valid_in), .fetch_addr_in(fetch_addr_in),
    .data_valid_in(data_valid_in), .data_addr_in(data_addr_in),
    .wdt_reset_req_out(wdt_reset_req_out), .dog_reset_cause_flag_out(dog_reset_cause_flag_out),
    .window_open_out(window_open_out));

// ### bench/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    import wdr_pkg::*;
    localparam int DIV = 2;
    localparam int HOLDN = 16;
    localparam int OVF = 1024 * DIV;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] opt = 8'h70;
    logic osc = 1'b1;
    logic [15:0] addr, fa, da;
    logic [7:0] wdata, rdata, d;
    logic wr, rd, bop, fv, dv, req, flag, wopen;
    logic [7:0] bad [3] = '{8'h55, 8'h00, 8'had};
    int num_errors = 0;
    int n_checks = 0;
    int waited;
    initial forever #5 clk_in = ~clk_in;
    wdr_top #(.LS_DIV(DIV), .HOLD(HOLDN)) u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .opt_byte_in(opt), .ls_osc_run_in(osc), .reg_addr_in(addr), .reg_wr_data_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_bit_op_in(bop), .reg_rd_data_out(rdata),
        .imem_size_in(8'h01), .xmem_size_in(8'h00), .fetch_valid_in(fv), .fetch_addr_in(fa),
        .data_valid_in(dv), .data_addr_in(da), .wdt_reset_req_out(req),
        .dog_reset_cause_flag_out(flag), .window_open_out(wopen));
    wdr_core_model u_core (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .bit_out(bop), .fv_out(fv),
        .fa_out(fa), .dv_out(dv), .da_out(da));
    task automatic conclude;
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic restart(input logic [7:0] o);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        opt <= o;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
    endtask
    // Watches for a reset request, then lets a raised one run out before returning.
    task automatic watch(input logic exp, input int n, input string nm);
        logic hit;
        hit = 1'b0;
        for (waited = 0; waited < n && !hit; waited++) begin
            @(posedge clk_in);
            #1 hit = req;
        end
        `CHK(nm, exp, hit)
        for (int i = 0; i < HOLDN + 2 && req !== 1'b0; i++) @(posedge clk_in);
        if (req !== 1'b0) begin
            num_errors++;
            conclude();
        end
    endtask
    initial begin
        restart(8'h70);
        u_core.rd(CLEAR_KEY_ADDR, d);
        `CHK("key read", KEY_READ_ENABLED, d)
        u_core.rd(16'h0100, d);
        `CHK("unmapped read", 8'h00, d)
        for (int i = 0; i < 3; i++) begin
            watch(1'b0, 1500, "cleared run");
            u_core.wr(CLEAR_KEY_ADDR, KEY_VALID, 1'b0);
        end
        u_core.rd(CLEAR_KEY_ADDR, d);
        `CHK("key read after write", KEY_READ_ENABLED, d)
        `CHK("window full", 1'b1, wopen)
        watch(1'b1, OVF + 100, "overflow");
        `CHK("overflow time", 1'b1, waited inside {[OVF - 2 * DIV:OVF + 2 * DIV + 2]})
        `CHK("cause flag", 1'b1, flag)
        u_core.rd(RESET_CAUSE_ADDR, d);
        `CHK("cause read", 8'h10, d)
        u_core.rd(RESET_CAUSE_ADDR, d);
        `CHK("cause cleared", 8'h00, d)
        for (int i = 0; i < 3; i++) begin
            u_core.wr(CLEAR_KEY_ADDR, bad[i], 1'b0);
            watch(1'b1, 3, "bad key");
        end
        u_core.wr(CLEAR_KEY_ADDR, KEY_VALID, 1'b1);
        watch(1'b1, 3, "bit write");
        u_core.acc(1'b1, 16'h0ffe);
        watch(1'b0, 5, "legal fetch");
        u_core.acc(1'b1, 16'h1000);
        watch(1'b1, 3, "bad fetch");
        u_core.acc(1'b0, EXEMPT_BASE);
        watch(1'b0, 5, "exempt data");
        u_core.acc(1'b0, 16'h2000);
        watch(1'b1, 3, "bad data");
        @(posedge clk_in);
        osc <= 1'b0;
        u_core.wr(CLEAR_KEY_ADDR, 8'h33, 1'b0);
        watch(1'b0, 8, "pended fault");
        @(posedge clk_in);
        osc <= 1'b1;
        watch(1'b1, 4 * DIV + 4, "resumed fault");
        restart(8'h12);
        u_core.wr(CLEAR_KEY_ADDR, KEY_VALID, 1'b0);
        watch(1'b0, 20, "first write");
        `CHK("window closed early", 1'b0, wopen)
        u_core.wr(CLEAR_KEY_ADDR, KEY_VALID, 1'b0);
        watch(1'b1, 3, "closed window");
        u_core.wr(CLEAR_KEY_ADDR, KEY_VALID, 1'b0);
        watch(1'b0, 3300, "closed part");
        `CHK("window open late", 1'b1, wopen)
        u_core.wr(CLEAR_KEY_ADDR, KEY_VALID, 1'b0);
        watch(1'b0, 20, "open window");
        restart(8'h0e);
        u_core.rd(CLEAR_KEY_ADDR, d);
        `CHK("key read off", KEY_READ_DISABLED, d)
        u_core.acc(1'b1, 16'h8000);
        watch(1'b0, 3000, "disabled");
        `CHK("window off", 1'b0, wopen)
        u_core.wr(CLEAR_KEY_ADDR, 8'h55, 1'b0);
        watch(1'b1, 3, "bad key off");
        conclude();
    end
endmodule
